//--- rtl/adc_state_and_reset_control.sv
// Converter state control: reset, sampling and converting, with ready and serial out
//
// What this block does
// - Three states, chosen by reset and start
// - Reset input acts without a clock
// - Reset: defaults, ready low, outputs tri-stated
// - After exit delay: sampling, ready high if chip select is high
// - Sampling, reset high: only start edges change state
// - Capture input, disconnect, internal oscillator clocking
// - Conversion end reconnects capacitors, back sampling
// - Converter gets reset, start; returns status, result
// - Eighteen-bit two's-complement result
// - Overrange saturates to fixed limit codes
// - Transfers timed internally, externally or mixed
// - Conversion time varies within min and max
// - Start rise in sampling converts; others ignored
// - Status low converting; ready follows when deselected
// - Reset fall in sampling enters reset
`include "adc_ctrl_defines.svh"

module adc_state_and_reset_control #(
  parameter int LANES      = 1,
  parameter int AIN_W      = 20,
  parameter int OSC_DIV    = `OSC_DIV,
  parameter int CONV_TICKS = `CONV_OSC_TICKS
) (
  input  wire logic                    mclk,                     // System clock
  input  wire logic                    reset_n,                  // Device reset, active low
  input  wire logic                    conversion_start_pin,     // Conversion start pin
  input  wire logic                    cs_n,                     // Chip select, active low
  input  wire logic                    sclk,                     // Host serial clock pin
  input  wire adc_ctrl_pkg::xfer_clk_t xfer_clock_sel,           // Transfer clock source
  input  wire logic signed [AIN_W-1:0] positive_analog_input,    // Positive input sample
  input  wire logic signed [AIN_W-1:0] negative_analog_input,    // Negative input sample
  output logic                         ready_strobe,             // Ready strobe pin
  output logic [LANES-1:0]             serial_output_lanes,      // Serial data out
  output logic [LANES-1:0]             serial_output_lanes_oe_n, // Data out enable, low
  output logic                         sampling_connect,         // Capacitors on inputs
  output logic                         converter_status,         // Internal status
  output logic [`CODE_W-1:0]           conversion_result,        // Latest result
  output adc_ctrl_pkg::dev_state_t     device_state              // Functional state
);

  localparam int EXIT_CYC = `RST_EXIT_CYC;
  localparam int EW       = $clog2(EXIT_CYC + 1);

  typedef struct packed {
    logic [2:0][1:0]          sync;
    logic [2:0]               prev;
    adc_ctrl_pkg::dev_state_t state;
    logic [EW-1:0]            exit_cnt;
    logic [`CODE_W-1:0]       result;
    logic [`CODE_W-1:0]       shreg;
    logic [LANES-1:0]         sdo;
    logic                     oe_n;
    logic                     ready;
    logic                     strobe;
  } ctl_t;

  ctl_t                    s;
  ctl_t                    next_s;
  adc_ctrl_pkg::conv_out_t cv;
  logic [2:0]              pins;
  logic [2:0]              lvl;
  logic                    conv_rise;
  logic                    cs_lvl;
  logic                    cs_fall;
  logic                    sclk_rise;
  logic                    launch;
  logic                    start;

  // ==========================================
  // Pin edges
  // Index 0 start, 1 chip select, 2 serial clock; all come from outside mclk.
  assign pins      = {sclk, cs_n, conversion_start_pin};
  assign lvl       = {s.sync[2][1], s.sync[1][1], s.sync[0][1]};
  assign conv_rise = lvl[0] & ~s.prev[0];
  assign cs_lvl    = lvl[1];
  assign cs_fall   = ~lvl[1] & s.prev[1];
  assign sclk_rise = lvl[2] & ~s.prev[2];

  // Mixed mode lets either clock launch a bit, so a host clock can pull
  // data faster than the internal strobe while the strobe still paces it.
  always_comb begin
    unique case (xfer_clock_sel)
      adc_ctrl_pkg::clk_internal: launch = cv.osc_tick;
      adc_ctrl_pkg::clk_external: launch = sclk_rise;
      adc_ctrl_pkg::clk_mixed:    launch = cv.osc_tick | sclk_rise;
      default:                    launch = 1'b0;
    endcase
  end

  // ==========================================
  // Converter
  conversion_sequencer #(
    .AIN_W      (AIN_W),
    .OSC_DIV    (OSC_DIV),
    .CONV_TICKS (CONV_TICKS)
  ) u_seq (
    .mclk    (mclk),
    .reset_n (reset_n),
    .start   (start),
    .pos_in  (positive_analog_input),
    .neg_in  (negative_analog_input),
    .cv      (cv)
  );

  // ==========================================
  // State and transfer logic
  always_comb begin
    next_s = s;
    start  = 1'b0;
    for (int i = 0; i < 3; i++) begin
      next_s.sync[i] = {s.sync[i][0], pins[i]};
      next_s.prev[i] = s.sync[i][1];
    end

    unique case (s.state)
      adc_ctrl_pkg::reset_state: begin
        if (s.exit_cnt == EW'(EXIT_CYC - 1)) begin
          next_s.state = adc_ctrl_pkg::sampling_state;
        end else begin
          next_s.exit_cnt = s.exit_cnt + 1'b1;
        end
      end
      adc_ctrl_pkg::sampling_state: begin
        if (conv_rise) begin
          next_s.state = adc_ctrl_pkg::converting_state;
          start        = 1'b1;
        end
      end
      adc_ctrl_pkg::converting_state: begin
        // Start edges are simply not looked at until the converter reports done
        if (cv.done) begin
          next_s.state  = adc_ctrl_pkg::sampling_state;
          next_s.result = cv.code;
        end
      end
      default: next_s.state = adc_ctrl_pkg::reset_state;
    endcase

    // A frame reads the last finished result; a conversion in flight
    // does not disturb the word being shifted out.
    if (cs_fall && s.state != adc_ctrl_pkg::reset_state) begin
      next_s.sdo    = s.result[`CODE_W-1 -: LANES];
      next_s.shreg  = s.result << LANES;
      next_s.oe_n   = 1'b0;
      next_s.strobe = 1'b0;
    end else if (!s.oe_n && launch) begin
      next_s.sdo    = s.shreg[`CODE_W-1 -: LANES];
      next_s.shreg  = s.shreg << LANES;
      next_s.strobe = ~s.strobe;
    end
    if (cs_lvl) begin
      next_s.oe_n = 1'b1;
    end

    if (next_s.state == adc_ctrl_pkg::reset_state) begin
      next_s.ready = 1'b0;
    end else if (cs_lvl) begin
      next_s.ready = cv.status;
    end else if (xfer_clock_sel == adc_ctrl_pkg::clk_external) begin
      next_s.ready = 1'b0;
    end else begin
      next_s.ready = next_s.strobe;
    end
  end

  // Reset enters the reset state from any state with no clock edge; a reset
  // pulse shorter than the host minimum still clears everything here.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s         <= '0;
      s.sync[1] <= 2'h3;
      s.prev[1] <= 1'b1;
      s.oe_n    <= 1'b1;
      s.state   <= adc_ctrl_pkg::reset_state;
      s.result  <= `RESULT_RST;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================
  // Outputs
  assign ready_strobe             = s.ready;
  assign serial_output_lanes      = s.sdo;
  assign serial_output_lanes_oe_n = {LANES{s.oe_n}};
  assign sampling_connect         = (s.state != adc_ctrl_pkg::converting_state);
  assign converter_status         = cv.status;
  assign conversion_result        = s.result;
  assign device_state             = s.state;

  // ==========================================
  // Checks
  reset_outputs_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (s.state == adc_ctrl_pkg::reset_state) |-> !ready_strobe && (&serial_output_lanes_oe_n))
    else $error("reset state must hold ready low and outputs off");

  exit_delay_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(reset_n) ##0 (s.state == adc_ctrl_pkg::reset_state) |->
      ##[1:EXIT_CYC] (s.state == adc_ctrl_pkg::sampling_state))
    else $error("reset exit too slow");

  exit_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (s.state == adc_ctrl_pkg::reset_state && s.exit_cnt < EW'(EXIT_CYC - 1))
      |=> s.state == adc_ctrl_pkg::reset_state)
    else $error("reset exit too early");

  ready_rise_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (s.state == adc_ctrl_pkg::reset_state && s.exit_cnt == EW'(EXIT_CYC - 1) && cs_lvl)
      |=> ready_strobe && s.state == adc_ctrl_pkg::sampling_state)
    else $error("ready not high on entering sampling");

  conv_start_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (s.state == adc_ctrl_pkg::sampling_state && conv_rise)
      |=> s.state == adc_ctrl_pkg::converting_state && !cv.status && !sampling_connect)
    else $error("start edge did not begin conversion");

  conv_ignore_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (s.state == adc_ctrl_pkg::converting_state && !cv.done)
      |=> s.state == adc_ctrl_pkg::converting_state)
    else $error("conversion left early");

  conv_end_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (s.state == adc_ctrl_pkg::converting_state && cv.done)
      |=> s.state == adc_ctrl_pkg::sampling_state && sampling_connect
          && conversion_result == $past(cv.code))
    else $error("conversion end not handled");

  idle_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (s.state == adc_ctrl_pkg::sampling_state && !conv_rise)
      |=> s.state == adc_ctrl_pkg::sampling_state)
    else $error("state changed without start edge");

  ready_follow_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (s.state != adc_ctrl_pkg::reset_state && cs_lvl) |=> ready_strobe == $past(cv.status))
    else $error("ready does not follow converter status");

  tristate_a: assert property (@(posedge mclk) disable iff (!reset_n)
    cs_lvl |=> (&serial_output_lanes_oe_n))
    else $error("outputs driven while deselected");

  // ==========================================
  // Converter hand-off checks
  busy_status_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (s.state == adc_ctrl_pkg::converting_state && !cv.done) |-> !converter_status)
    else $error("converter idle while converting");

  status_idle_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (s.state == adc_ctrl_pkg::sampling_state) |-> converter_status)
    else $error("converter busy while sampling");

  seq_start_a: assert property (@(posedge mclk) disable iff (!reset_n)
    start |=> !converter_status && device_state == adc_ctrl_pkg::converting_state)
    else $error("converter did not take the start");

  result_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (s.state != adc_ctrl_pkg::converting_state) |=> $stable(conversion_result))
    else $error("result changed outside conversion end");

  // ==========================================
  // Frame checks
  // These compare against the registered words one edge back, so a
  // conversion that ends in mid-frame cannot hide a wrong bit.
  frame_load_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (cs_fall && s.state != adc_ctrl_pkg::reset_state)
      |=> !serial_output_lanes_oe_n[0]
          && serial_output_lanes == $past(s.result[`CODE_W-1 -: LANES]))
    else $error("frame did not load the last result");

  frame_ready_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (cs_fall && s.state != adc_ctrl_pkg::reset_state) |=> !ready_strobe)
    else $error("ready not low at frame start");

  shift_step_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (!s.oe_n && launch && !cs_fall)
      |=> serial_output_lanes == $past(s.shreg[`CODE_W-1 -: LANES]))
    else $error("launch did not shift the next bit");

  sdo_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (!s.oe_n && !launch && !cs_fall) |=> $stable(serial_output_lanes))
    else $error("data changed without a launch");

  oe_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (!s.oe_n && !cs_lvl) |=> !serial_output_lanes_oe_n[0])
    else $error("outputs released inside a frame");

  int_strobe_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (!s.oe_n && !cs_lvl && !cs_fall && cv.osc_tick
      && xfer_clock_sel == adc_ctrl_pkg::clk_internal)
      |=> ready_strobe == !$past(s.strobe))
    else $error("internal strobe did not toggle");

  ext_ready_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (s.state != adc_ctrl_pkg::reset_state && !cs_lvl
      && xfer_clock_sel == adc_ctrl_pkg::clk_external) |=> !ready_strobe)
    else $error("ready high in an external clock frame");

endmodule

//--- rtl/adc_ctrl_defines.svh
// Timing counts, code limits and reset values for the converter control block
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

// ==========================================
// Clock and timing
`define MCLK_MHZ        25
`define RST_EXIT_NS     1000
`define RST_EXIT_CYC    ((`RST_EXIT_NS * `MCLK_MHZ + 999) / 1000)
`define CONV_MIN_NS     700
`define CONV_MAX_NS     1000
`define CONV_MIN_CYC    ((`CONV_MIN_NS * `MCLK_MHZ + 999) / 1000)
`define CONV_MAX_CYC    ((`CONV_MAX_NS * `MCLK_MHZ) / 1000)
`define OSC_DIV         2
`define CONV_OSC_TICKS  10

// ==========================================
// Output coding
`define CODE_W          18
`define CODE_POS_MAX    18'h1ffff
`define CODE_NEG_MAX    18'h20000
`define RESULT_RST      18'h00000

`endif

//--- rtl/adc_ctrl_pkg.sv
// Types shared by the converter control block and its conversion sequencer
`include "adc_ctrl_defines.svh"

package adc_ctrl_pkg;

  typedef enum logic [1:0] {
    reset_state      = 2'h0,
    sampling_state   = 2'h1,
    converting_state = 2'h3
  } dev_state_t;

  typedef enum logic [1:0] {
    clk_internal = 2'h0,
    clk_external = 2'h1,
    clk_mixed    = 2'h3
  } xfer_clk_t;

  typedef struct packed {
    logic                 status;
    logic                 done;
    logic                 osc_tick;
    logic [`CODE_W-1:0]   code;
  } conv_out_t;

endpackage

//--- rtl/conversion_sequencer.sv
// Converter sub-module: sample capture, oscillator-timed conversion, result coding
`include "adc_ctrl_defines.svh"

module conversion_sequencer #(
  parameter int AIN_W      = 20,
  parameter int OSC_DIV    = `OSC_DIV,
  parameter int CONV_TICKS = `CONV_OSC_TICKS
) (
  input  wire logic                    mclk,      // System clock
  input  wire logic                    reset_n,   // Asynchronous reset, active low
  input  wire logic                    start,     // One-cycle conversion start
  input  wire logic signed [AIN_W-1:0] pos_in,    // Positive input sample
  input  wire logic signed [AIN_W-1:0] neg_in,    // Negative input sample
  output adc_ctrl_pkg::conv_out_t      cv         // Status, done, tick and code
);

  localparam int OW      = $clog2(OSC_DIV);
  localparam int CW      = $clog2(CONV_TICKS + 1);
  localparam int CONV_LO = `CONV_MIN_CYC;
  localparam int CONV_HI = `CONV_MAX_CYC;
  localparam logic signed [AIN_W:0] POS_LIM =
    signed'({{(AIN_W + 1 - `CODE_W){1'b0}}, `CODE_POS_MAX});
  localparam logic signed [AIN_W:0] NEG_LIM =
    signed'({{(AIN_W + 1 - `CODE_W){1'b1}}, `CODE_NEG_MAX});

  typedef struct packed {
    logic [OW-1:0]      osc;
    logic               busy;
    logic [CW-1:0]      ticks;
    logic [`CODE_W-1:0] held;
    logic               done;
    logic [`CODE_W-1:0] code;
  } seq_t;

  seq_t                    s;
  seq_t                    next_s;
  logic signed [AIN_W:0]   diff;
  logic                    tick;
  logic [7:0]              busy_len;

  function automatic logic [`CODE_W-1:0] saturate(input logic signed [AIN_W:0] d);
    if (d > POS_LIM) begin
      return `CODE_POS_MAX;
    end else if (d < NEG_LIM) begin
      return `CODE_NEG_MAX;
    end
    return d[`CODE_W-1:0];
  endfunction

  assign diff = $signed({pos_in[AIN_W-1], pos_in}) - $signed({neg_in[AIN_W-1], neg_in});
  assign tick = (s.osc == OW'(OSC_DIV - 1));

  // ==========================================
  // Sequencer
  // The oscillator divider runs free, so a conversion lasts up to OSC_DIV - 1 cycles
  // more or less depending on where the start lands against it.
  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    next_s.osc  = tick ? '0 : s.osc + 1'b1;
    if (!s.busy && start) begin
      next_s.busy  = 1'b1;
      next_s.ticks = '0;
      next_s.held  = saturate(diff);
    end else if (s.busy && tick) begin
      if (s.ticks == CW'(CONV_TICKS - 1)) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
        next_s.code = s.held;
      end else begin
        next_s.ticks = s.ticks + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s      <= '0;
      s.code <= `RESULT_RST;
    end else begin
      s <= next_s;
    end
  end

  // One driver for the whole carrier: status, done pulse, oscillator tick, code
  assign cv = {~s.busy, s.done, tick, s.code};

  // ==========================================
  // Checks
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      busy_len <= '0;
    end else begin
      busy_len <= s.busy ? busy_len + 8'h01 : 8'h00;
    end
  end

  conv_window_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $fell(s.busy) |-> (busy_len >= CONV_LO) && (busy_len <= CONV_HI))
    else $error("conversion time outside window");

  sat_high_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (!s.busy && start && diff > POS_LIM) |=> s.held == `CODE_POS_MAX)
    else $error("positive overrange not saturated");

  sat_low_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (!s.busy && start && diff < NEG_LIM) |=> s.held == `CODE_NEG_MAX)
    else $error("negative overrange not saturated");

  conv_ends_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(s.busy) |-> ##[1:CONV_HI] cv.done)
    else $error("conversion did not finish in time");

endmodule

//--- testbench/host_model.sv
// Host controller model: drives reset, conversion start, chip select and serial clock
module host_model #(
  parameter int RESET_LOW_CYC = 3  // Reset low width in clock cycles
) (
  input  wire logic mclk,                  // System clock
  output logic      reset_n,               // Device reset, active low
  output logic      conversion_start_pin,  // Conversion start
  output logic      cs_n,                  // Chip select, active low
  output logic      sclk                   // Serial clock, still outside frames
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================
  // Pin levels
  initial begin
    reset_n = 1'b0;
    conversion_start_pin = 1'b0;
    cs_n = 1'b1;
    sclk = 1'b0;
  end

  // Held until the RESET_LOW_CYC-th clock edge, so entering in mid-cycle shortens the width
  task automatic enter_reset();
    reset_n = 1'b0;
    repeat (RESET_LOW_CYC) @(posedge mclk);
    #2;
  endtask

  task automatic leave_reset();
    conversion_start_pin = 1'b0;
    sclk = 1'b0;
    cs_n = 1'b1;
    reset_n = 1'b1;
  endtask

  task automatic set_start(input logic v);
    conversion_start_pin = v;
  endtask

  task automatic select(input logic active);
    cs_n = ~active;
  endtask

  // Slow enough per phase for the pin synchronizer to see every edge
  task automatic sclk_cycle(input int half);
    sclk = 1'b1;
    repeat (half) @(posedge mclk);
    #2;
    sclk = 1'b0;
    repeat (half) @(posedge mclk);
    #2;
  endtask
endmodule

//--- testbench/adc_state_and_reset_control_tb.sv
// Self-checking bench for the converter state and reset control block
`include "adc_ctrl_defines.svh"
module adc_state_and_reset_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int AIN_W = 20;

  // ==========================================
  // Signals and instances
  logic                    mclk = 1'b0;
  logic                    reset_n;
  logic                    conversion_start_pin;
  logic                    cs_n;
  logic                    sclk;
  adc_ctrl_pkg::xfer_clk_t xfer_clock_sel;
  logic signed [AIN_W-1:0] pos_in;
  logic signed [AIN_W-1:0] neg_in;
  logic                    ready_strobe;
  logic [0:0]              sdo;
  logic [0:0]              sdo_oe_n;
  logic                    sampling_connect;
  logic                    converter_status;
  logic [`CODE_W-1:0]      conversion_result;
  adc_ctrl_pkg::dev_state_t device_state;
  int                      err_count = 0;
  int                      n_tests = 0;

  always #20 mclk = ~mclk;

  host_model host_model_i (
    .mclk(mclk), .reset_n(reset_n), .conversion_start_pin(conversion_start_pin),
    .cs_n(cs_n), .sclk(sclk));

  adc_state_and_reset_control #(.AIN_W(AIN_W))
    adc_state_and_reset_control_i (
    .mclk(mclk), .reset_n(reset_n), .conversion_start_pin(conversion_start_pin),
    .cs_n(cs_n), .sclk(sclk), .xfer_clock_sel(xfer_clock_sel),
    .positive_analog_input(pos_in), .negative_analog_input(neg_in),
    .ready_strobe(ready_strobe), .serial_output_lanes(sdo),
    .serial_output_lanes_oe_n(sdo_oe_n), .sampling_connect(sampling_connect),
    .converter_status(converter_status), .conversion_result(conversion_result),
    .device_state(device_state));

  // ==========================================
  // Helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  task automatic wait_state(input adc_ctrl_pkg::dev_state_t s, input int lim, output int n);
    n = 0;
    while (device_state !== s && n < lim) begin
      tick(1);
      n++;
    end
  endtask

  function automatic logic [`CODE_W-1:0] coded(input int p, input int m);
    int d;
    d = p - m;
    if (d > 32'sh1ffff) return `CODE_POS_MAX;
    if (d < -32'sh20000) return `CODE_NEG_MAX;
    return d[`CODE_W-1:0];
  endfunction

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ==========================================
  // Scenarios
  task automatic reset_exit();
    int n;
    host_model_i.enter_reset();
    check("state in reset", device_state, adc_ctrl_pkg::reset_state);
    check("ready in reset", ready_strobe, 1'b0);
    check("oe in reset", sdo_oe_n, 1'b1);
    check("result in reset", conversion_result, `RESULT_RST);
    host_model_i.leave_reset();
    wait_state(adc_ctrl_pkg::sampling_state, 40, n);
    check("exit delay", n >= `RST_EXIT_CYC - 2 && n <= `RST_EXIT_CYC + 1, 1'b1);
    tick(2);
    check("ready after exit", ready_strobe, 1'b1);
    check("capacitors on", sampling_connect, 1'b1);
  endtask

  // Start edges inside the conversion must not start a second one
  task automatic convert(input int p, input int m);
    int n;
    int conv;
    pos_in = p[AIN_W-1:0];
    neg_in = m[AIN_W-1:0];
    host_model_i.set_start(1'b1);
    wait_state(adc_ctrl_pkg::converting_state, 6, n);
    check("start taken", device_state, adc_ctrl_pkg::converting_state);
    check("capacitors off", sampling_connect, 1'b0);
    check("status busy", converter_status, 1'b0);
    conv = 1;
    while (device_state === adc_ctrl_pkg::converting_state && conv < 40) begin
      if (conv == 2) host_model_i.set_start(1'b0);
      if (conv == 3) check("ready busy", ready_strobe, 1'b0);
      if (conv == 3) pos_in = ~pos_in;
      if (conv == 5) host_model_i.set_start(1'b1);
      if (conv == 8) host_model_i.set_start(1'b0);
      tick(1);
      conv++;
    end
    check("conv time", conv - 1 >= `CONV_MIN_CYC && conv - 1 <= `CONV_MAX_CYC, 1'b1);
    check("back to sampling", device_state, adc_ctrl_pkg::sampling_state);
    check("capacitors back", sampling_connect, 1'b1);
    check("status done", converter_status, 1'b1);
    check("result", conversion_result, coded(p, m));
    tick(4);
    check("late start ignored", device_state, adc_ctrl_pkg::sampling_state);
    check("ready done", ready_strobe, 1'b1);
  endtask

  task automatic frame(input adc_ctrl_pkg::xfer_clk_t mode, input logic [`CODE_W-1:0] exp);
    logic [`CODE_W-1:0] word;
    logic               last_ready;
    int                 n;
    xfer_clock_sel = mode;
    host_model_i.select(1'b1);
    n = 0;
    while (sdo_oe_n !== 1'b0 && n < 6) begin
      tick(1);
      n++;
    end
    check("frame enabled", sdo_oe_n, 1'b0);
    word[`CODE_W-1] = sdo[0];
    for (int i = `CODE_W - 2; i >= 0; i--) begin
      if (mode == adc_ctrl_pkg::clk_external) host_model_i.sclk_cycle(4);
      else begin
        last_ready = ready_strobe;
        n = 0;
        while (ready_strobe === last_ready && n < 8) begin
          tick(1);
          n++;
        end
      end
      word[i] = sdo[0];
    end
    check("frame word", word, exp);
    host_model_i.select(1'b0);
    tick(6);
    check("frame released", sdo_oe_n, 1'b1);
    check("ready idle", ready_strobe, 1'b1);
  endtask

  // Reset asserted off the clock edge must act before the next edge
  task automatic reset_async();
    int n;
    #10;
    fork
      host_model_i.enter_reset();
      begin
        #5;
        check("async state", device_state, adc_ctrl_pkg::reset_state);
        check("async ready", ready_strobe, 1'b0);
        check("async oe", sdo_oe_n, 1'b1);
      end
    join
    check("reset result", conversion_result, `RESULT_RST);
    host_model_i.leave_reset();
    wait_state(adc_ctrl_pkg::sampling_state, 40, n);
    check("exit again", device_state, adc_ctrl_pkg::sampling_state);
    tick(3);
  endtask

  // ==========================================
  // Main sequence and watchdog
  int pv[6] = '{32'sh64, 32'sh0, 32'sh1, 32'sh30000, 32'sh0, 32'sh0};
  int nv[6] = '{32'sh64, 32'sh1, 32'sh0, 32'sh0, 32'sh30000, 32'sh1ffff};

  initial begin
    xfer_clock_sel = adc_ctrl_pkg::clk_internal;
    pos_in = '0;
    neg_in = '0;
    reset_exit();
    foreach (pv[i]) convert(pv[i], nv[i]);
    frame(adc_ctrl_pkg::clk_internal, 18'h20001);
    convert(32'sh30000, 32'sh0);
    frame(adc_ctrl_pkg::clk_external, 18'h1ffff);
    convert(32'sh155, 32'sh0);
    frame(adc_ctrl_pkg::clk_mixed, 18'h00155);
    reset_async();
    host_model_i.set_start(1'b1);
    tick(5);
    check("converting before reset", device_state, adc_ctrl_pkg::converting_state);
    reset_async();
    final_report();
  end

  // Run needs about 550 cycles; nine times that is a hang
  initial begin
    #(40 * 5000);
    err_count++;
    $display("watchdog expired");
    final_report();
  end
endmodule
